// >>> shared/ipd_pkg.sv
// Package of types and constants for the indexed postbyte decoder
`default_nettype none
package ipd_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] IPD_PAGE2_PREFIX = 8'h18;
    localparam logic [1:0] IPD_REG_X        = 2'h0;
    localparam logic [1:0] IPD_REG_Y        = 2'h1;
    localparam logic [1:0] IPD_REG_SP       = 2'h2;
    localparam logic [1:0] IPD_REG_PC       = 2'h3;
    localparam logic [1:0] IPD_ACC_A        = 2'h0;
    localparam logic [1:0] IPD_ACC_B        = 2'h1;
    localparam logic [1:0] IPD_ACC_D        = 2'h2;
    localparam logic [1:0] IPD_ACC_DIND     = 2'h3;
    localparam int         IPD_SEL_POS      = 6;
    localparam int         IPD_AUTO_POS     = 5;
    localparam int         IPD_PRE_POS      = 4;

    // Offset source chosen by the postbyte
    typedef enum logic [5:0] {
        IPD_OFS_CONST5  = 6'h01,
        IPD_OFS_CONST9  = 6'h02,
        IPD_OFS_CONST16 = 6'h04,
        IPD_OFS_AUTO    = 6'h08,
        IPD_OFS_ACC     = 6'h10,
        IPD_OFS_NONE    = 6'h20
    } ipd_ofs_t;

    typedef enum logic [2:0] {
        IPD_ST_OPCODE = 3'h1,
        IPD_ST_POST   = 3'h2,
        IPD_ST_EXT    = 3'h4
    } ipd_state_t;

    // Fully decoded indexed operand
    typedef struct packed {
        logic [1:0]  index_register_select;
        ipd_ofs_t    ofs_kind;
        logic        indirect;
        logic        auto_pre;
        logic        auto_post;
        logic        invalid;
        logic [1:0]  acc_sel;
        logic [1:0]  ext_count;
        logic [15:0] offset;
    } ipd_decode_t;
endpackage : ipd_pkg
`default_nettype wire

// >>> design/ipd_decoder.sv
// Indexed postbyte and opcode page decoder
//
// Overview of operation
// - rr0nnnnn: signed five-bit offset, -16..+15
// - 111rr0zs: nine-bit or sixteen-bit signed offset
// - 111rr011: sixteen-bit offset, indirect pointer
// - rr1pnnnn: auto adjust, p selects pre/post
// - Auto step -8..-1 or +1..+8, never zero
// - Auto adjust only X, Y, SP
// - 111rr1aa: unsigned A, B or D offset
// - 111rr111: D offset, indirect, any register
// - Postbyte gives zero to two extension bytes
// - Prefix 18 selects second opcode page
// - Extension bytes delivered to the datapath
// - Nine-bit low byte, sixteen-bit two bytes
`default_nettype none
module ipd_decoder (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    // Instruction byte stream
    input  wire logic            byte_valid,
    input  wire logic [7:0]      byte_data,
    input  wire logic            opcode_is_indexed,
    // Decoded opcode
    output logic                 opcode_valid,
    output logic [7:0]           opcode,
    output logic                 opcode_page2,
    // Decoded indexed operand
    output logic                 decode_valid,
    output ipd_pkg::ipd_decode_t decode,
    output logic [7:0]           indexed_postbyte
);
    timeunit 1ns;
    timeprecision 1ps;
    import ipd_pkg::*;

    // Sequencing state
    ipd_state_t  state, next_state;
    logic        page2, next_page2;
    logic [1:0]  ext_left, next_ext_left;

    // Opcode state
    logic        op_v, next_op_v;
    logic [7:0]  op, next_op;
    logic        op_p2, next_op_p2;

    // Operand state
    logic        dv, next_dv;
    ipd_decode_t dec, next_dec;
    logic [7:0]  pb, next_pb;

    // Role of the byte on the stream this cycle
    logic        take_prefix;
    logic        take_opcode;
    logic        take_post;
    logic        take_ext;
    logic        last_ext;
    logic        post_done;

    // Postbyte fields and their meaning
    logic [1:0]  sel_short;
    logic [1:0]  sel_long;
    logic [1:0]  sel_eff;
    logic        is_short;
    logic        is_long;
    logic        is_const_long;
    logic        long_acc;
    logic [1:0]  long_low;
    logic [3:0]  step_field;
    logic [15:0] step_value;
    logic [15:0] short_value;
    logic [1:0]  ext_need;

    // Decode of the byte on the stream, used when it is a postbyte
    ipd_decode_t pb_dec;
    logic [15:0] ext_offset;

    // Select bits move to 4:3 once the top three bits are all set
    assign is_short      = ~byte_data[IPD_AUTO_POS];
    assign is_long       = (byte_data[7:5] == 3'h7);
    assign is_const_long = is_long && !byte_data[2];
    assign sel_short     = byte_data[IPD_SEL_POS+1:IPD_SEL_POS];
    assign sel_long      = byte_data[4:3];
    assign long_acc      = byte_data[2];
    assign long_low      = byte_data[1:0];
    assign step_field    = byte_data[3:0];
    assign short_value   = {{11{byte_data[4]}}, byte_data[4:0]};

    // Field 0..7 is +1..+8, 8..F is -8..-1, so a zero step cannot occur
    always_comb begin
        if (step_field[3]) begin
            step_value = {12'hFFF, step_field};
        end else begin
            step_value = {12'h000, step_field} + 16'h0001;
        end
    end

    // Only the constant long forms carry extension bytes
    always_comb begin
        ext_need = 2'h0;
        if (is_const_long) begin
            if (long_low[1]) begin
                ext_need = 2'h2;
            end else begin
                ext_need = 2'h1;
            end
        end
    end

    // Register select field for this postbyte form
    always_comb begin
        if (is_long) begin
            sel_eff = sel_long;
        end else begin
            sel_eff = sel_short;
        end
    end

    // Pure postbyte decode
    always_comb begin
        pb_dec = '0;
        pb_dec.ofs_kind = IPD_OFS_NONE;
        pb_dec.ext_count = ext_need;
        pb_dec.index_register_select = sel_eff;
        if (is_const_long) begin
            if (long_low[1]) begin
                pb_dec.ofs_kind = IPD_OFS_CONST16;
                pb_dec.indirect = long_low[0];
            end else begin
                pb_dec.ofs_kind = IPD_OFS_CONST9;
                // Sign waits in the high byte until the low byte arrives
                pb_dec.offset = {{8{long_low[0]}}, 8'h00};
            end
        end else if (is_long) begin
            pb_dec.ofs_kind = IPD_OFS_ACC;
            pb_dec.indirect = (long_low == IPD_ACC_DIND);
            if (long_low == IPD_ACC_DIND) begin
                pb_dec.acc_sel = IPD_ACC_D;
            end else begin
                pb_dec.acc_sel = long_low;
            end
        end else if (is_short) begin
            pb_dec.ofs_kind = IPD_OFS_CONST5;
            pb_dec.offset = short_value;
        end else begin
            pb_dec.ofs_kind = IPD_OFS_AUTO;
            pb_dec.auto_pre = ~byte_data[IPD_PRE_POS];
            pb_dec.auto_post = byte_data[IPD_PRE_POS];
            pb_dec.offset = step_value;
            // A program counter code reads as a long form, so this only guards
            pb_dec.invalid = (sel_short == IPD_REG_PC);
        end
    end

    // A second prefix in a row is taken as an ordinary opcode
    always_comb begin
        take_prefix = 1'b0;
        take_opcode = 1'b0;
        take_post = 1'b0;
        take_ext = 1'b0;
        case (state)
            IPD_ST_OPCODE: begin
                if (byte_valid && byte_data == IPD_PAGE2_PREFIX && !page2) begin
                    take_prefix = 1'b1;
                end else begin
                    take_opcode = byte_valid;
                end
            end
            IPD_ST_POST: begin
                take_post = byte_valid;
            end
            IPD_ST_EXT: begin
                take_ext = byte_valid;
            end
            default: begin
                take_opcode = 1'b0;
            end
        endcase
    end

    assign last_ext  = take_ext && (ext_left == 2'h1);
    assign post_done = take_post && (ext_need == 2'h0);

    // Sequencing: which role the next byte plays
    always_comb begin
        next_state = state;
        next_page2 = page2;
        next_ext_left = ext_left;
        case (state)
            IPD_ST_OPCODE: begin
                if (take_prefix) begin
                    next_page2 = 1'b1;
                end else if (take_opcode) begin
                    next_page2 = 1'b0;
                    if (opcode_is_indexed) begin
                        next_state = IPD_ST_POST;
                    end
                end
            end
            IPD_ST_POST: begin
                if (take_post) begin
                    next_ext_left = ext_need;
                    if (ext_need == 2'h0) begin
                        next_state = IPD_ST_OPCODE;
                    end else begin
                        next_state = IPD_ST_EXT;
                    end
                end
            end
            IPD_ST_EXT: begin
                if (take_ext) begin
                    next_ext_left = ext_left - 2'h1;
                    if (last_ext) begin
                        next_state = IPD_ST_OPCODE;
                    end
                end
            end
            default: begin
                next_state = IPD_ST_OPCODE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state    <= IPD_ST_OPCODE;
            page2    <= 1'b0;
            ext_left <= 2'h0;
        end else begin
            state    <= next_state;
            page2    <= next_page2;
            ext_left <= next_ext_left;
        end
    end

    // Opcode: one-cycle pulse, opcode and page flag held
    always_comb begin
        next_op_v = take_opcode;
        next_op = op;
        next_op_p2 = op_p2;
        if (take_opcode) begin
            next_op = byte_data;
            next_op_p2 = page2;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            op_v  <= 1'b0;
            op    <= 8'h00;
            op_p2 <= 1'b0;
        end else begin
            op_v  <= next_op_v;
            op    <= next_op;
            op_p2 <= next_op_p2;
        end
    end

    // Nine-bit form keeps its sign byte; sixteen-bit form shifts, high byte first
    always_comb begin
        if (dec.ofs_kind == IPD_OFS_CONST9) begin
            ext_offset = {dec.offset[15:8], byte_data};
        end else begin
            ext_offset = {dec.offset[7:0], byte_data};
        end
    end

    // Operand: a held decode, refined by each extension byte
    always_comb begin
        next_dv = 1'b0;
        next_dec = dec;
        next_pb = pb;
        if (take_post) begin
            next_pb = byte_data;
            next_dec = pb_dec;
            next_dv = post_done;
        end else if (take_ext) begin
            next_dec.offset = ext_offset;
            next_dv = last_ext;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dv  <= 1'b0;
            dec <= '0;
            pb  <= 8'h00;
        end else begin
            dv  <= next_dv;
            dec <= next_dec;
            pb  <= next_pb;
        end
    end

    // Outputs straight from the registers
    assign opcode_valid     = op_v;
    assign opcode           = op;
    assign opcode_page2     = op_p2;
    assign decode_valid     = dv;
    assign decode           = dec;
    assign indexed_postbyte = pb;
endmodule : ipd_decoder
`default_nettype wire

// >>> verification/ipd_decoder_properties.sv
// Port assertions for the indexed postbyte decoder
`default_nettype none
module ipd_decoder_properties import ipd_pkg::*; (
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    // Byte stream
    input wire logic                 byte_valid,
    input wire logic [7:0]           byte_data,
    input wire logic                 opcode_is_indexed,
    // Decoded outputs
    input wire logic                 opcode_valid,
    input wire logic [7:0]           opcode,
    input wire logic                 opcode_page2,
    input wire logic                 decode_valid,
    input wire ipd_pkg::ipd_decode_t decode,
    input wire logic [7:0]           indexed_postbyte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_opc_taken: assert property (opcode_valid |-> $past(byte_valid)
        && opcode == $past(byte_data)) else $error("opcode not from taken byte");
    a_dec_taken: assert property (decode_valid |-> $past(byte_valid))
        else $error("decode without a byte");
    a_sel_field: assert property (decode_valid |-> decode.index_register_select ==
        (indexed_postbyte[7:5] == 3'h7 ? indexed_postbyte[4:3] : indexed_postbyte[7:6]))
        else $error("bad select");
    a_short_ofs: assert property (decode_valid && !indexed_postbyte[5] |->
        decode.ext_count == 2'h0 && decode.offset == {{11{indexed_postbyte[4]}},
        indexed_postbyte[4:0]}) else $error("bad short offset");
    a_auto_step: assert property (decode_valid && decode.ofs_kind == IPD_OFS_AUTO |->
        decode.offset != 16'h0 && decode.auto_pre == !indexed_postbyte[4])
        else $error("bad auto step");
    a_auto_pc: assert property (decode_valid && decode.ofs_kind == IPD_OFS_AUTO |->
        decode.invalid == (decode.index_register_select == IPD_REG_PC)) else $error("pc flag");
    a_nine_ext: assert property (decode_valid && decode.ofs_kind == IPD_OFS_CONST9 |->
        decode.ext_count == 2'h1 && decode.offset[15:8] == {8{indexed_postbyte[0]}})
        else $error("bad nine-bit form");
    a_ind_acc: assert property (decode_valid && indexed_postbyte[7:5] == 3'h7
        && indexed_postbyte[2:0] == 3'h7 |-> decode.indirect && decode.acc_sel == IPD_ACC_D)
        else $error("bad indirect D");
endmodule : ipd_decoder_properties
bind ipd_decoder ipd_decoder_properties i_props (.clk_sys, .rstn, .byte_valid, .byte_data,
    .opcode_is_indexed, .opcode_valid, .opcode, .opcode_page2, .decode_valid, .decode,
    .indexed_postbyte);
`default_nettype wire

// >>> verification/tb_ipd_decoder.sv
// Self-checking bench for the indexed postbyte decoder
`default_nettype none
module tb_ipd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import ipd_pkg::*;
    logic        clk_sys, rstn, byte_valid, opcode_is_indexed, pf;
    logic        opcode_valid, opcode_page2, decode_valid;
    logic [7:0]  byte_data, opcode, indexed_postbyte, op, h, l;
    ipd_decode_t decode, e;
    int          fail_count, samples_checked;
    ipd_decoder i_ipd_decoder (.clk_sys, .rstn, .byte_valid, .byte_data, .opcode_is_indexed,
        .opcode_valid, .opcode, .opcode_page2, .decode_valid, .decode, .indexed_postbyte);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        samples_checked++;
        if (s !== x) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // Held high between bytes so no signal is set twice in one step
    task automatic put(input logic [7:0] b, input logic ix);
        byte_valid = 1'b1;
        byte_data = b;
        opcode_is_indexed = ix;
        @(negedge clk_sys);
    endtask : put
    function automatic ipd_decode_t model(input logic [7:0] p, hi, lo);
        ipd_decode_t m;
        m = '0;
        m.index_register_select = (p[7:5] == 3'h7) ? p[4:3] : p[7:6];
        if (!p[5]) begin
            m.ofs_kind = IPD_OFS_CONST5;
            m.offset = {{11{p[4]}}, p[4:0]};
        end else if (p[7:5] != 3'h7) begin
            m.ofs_kind = IPD_OFS_AUTO;
            m.auto_pre = !p[4];
            m.auto_post = p[4];
            m.invalid = (p[7:6] == IPD_REG_PC);
            m.offset = p[3] ? {12'hFFF, p[3:0]} : 16'(p[3:0]) + 16'h1;
        end else if (!p[2]) begin
            m.ofs_kind = p[1] ? IPD_OFS_CONST16 : IPD_OFS_CONST9;
            m.indirect = p[1] & p[0];
            m.ext_count = p[1] ? 2'h2 : 2'h1;
            m.offset = p[1] ? {hi, lo} : {{8{p[0]}}, hi};
        end else begin
            m.ofs_kind = IPD_OFS_ACC;
            m.indirect = &p[1:0];
            m.acc_sel = (&p[1:0]) ? IPD_ACC_D : p[1:0];
        end
        return m;
    endfunction : model
    initial begin
        #60000;
        fail_count++;
        final_report;
    end
    initial begin
        {rstn, byte_valid, byte_data, opcode_is_indexed} = '0;
        fail_count = 0;
        samples_checked = 0;
        h = 8'($urandom(32'h9BAEE7DD));
        repeat (5) @(negedge clk_sys);
        chk({opcode_valid, decode_valid}, 0);
        rstn = 1'b1;
        // Every postbyte code once, random opcodes, page and extension bytes
        for (int i = 0; i < 256; i++) begin
            pf = 1'($urandom_range(1));
            op = 8'h80 | 8'($urandom);
            h = 8'($urandom);
            l = 8'($urandom);
            e = model(i[7:0], h, l);
            if (pf) put(IPD_PAGE2_PREFIX, 1'b0);
            put(op, 1'b1);
            chk({opcode_valid, opcode_page2, opcode}, {1'b1, pf, op});
            put(i[7:0], 1'b0);
            if (e.ext_count > 0) begin
                chk(decode_valid, 0);
                put(h, 1'b0);
            end
            if (e.ext_count > 1) begin
                chk(decode_valid, 0);
                put(l, 1'b0);
            end
            chk({decode_valid, opcode_valid}, 2'h2);
            chk(decode, e);
            chk(indexed_postbyte, i[7:0]);
            if (i % 4 == 0) begin
                put(op ^ 8'h01, 1'b0);
                chk({opcode_valid, decode_valid, opcode}, {2'h2, op ^ 8'h01});
                chk(decode, e);
            end
            if ($urandom_range(1)) begin
                byte_valid = 1'b0;
                @(negedge clk_sys);
            end
        end
        rstn = 1'b0;
        @(negedge clk_sys);
        chk({opcode_valid, opcode_page2, decode_valid, decode, indexed_postbyte, opcode}, 0);
        // Restart after a mid-run reset; a second prefix in a row is an opcode
        rstn = 1'b1;
        put(IPD_PAGE2_PREFIX, 1'b0);
        put(IPD_PAGE2_PREFIX, 1'b0);
        chk({opcode_valid, opcode_page2, decode_valid, opcode}, {3'h6, IPD_PAGE2_PREFIX});
        final_report;
    end
endmodule : tb_ipd_decoder
`default_nettype wire
